// ### verilog/epiu_pkg.sv
package epiu_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets and word indices
    // ------------------------------------------------------------------
    localparam logic [31:0] OFS_SENSE = 32'h0000_0000;
    localparam logic [31:0] OFS_MASK = 32'h0000_0004;
    localparam logic [31:0] OFS_FLAG = 32'h0000_0008;
    localparam logic [31:0] OFS_PCMASK = 32'h0000_000c;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0010;

    localparam logic [2:0] IDX_SENSE = 3'h0;
    localparam logic [2:0] IDX_MASK = 3'h1;
    localparam logic [2:0] IDX_FLAG = 3'h2;
    localparam logic [2:0] IDX_PCMASK = 3'h3;
    localparam logic [2:0] IDX_STATUS = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int PC_COUNT = 6;
    localparam int BIT_DEDICATED = 6;
    localparam int BIT_PIN_CHANGE = 5;
    localparam int BIT_GLOBAL_EN = 7;

    // ------------------------------------------------------------------
    // Sense modes of the dedicated pin
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SENSE_LOW = 2'h0,
        SENSE_ANY = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } epiu_sense_t;

    // ------------------------------------------------------------------
    // Complete state of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        epiu_sense_t sense;
        logic en_int;
        logic en_pc;
        logic flag_int;
        logic flag_pc;
        logic gie;
        logic [PC_COUNT-1:0] pcmask;
        logic pin_s;
        logic pin_p;
        logic [PC_COUNT-1:0] pc_s;
        logic [PC_COUNT-1:0] pc_p;
        logic wr_pend;
        logic [2:0] widx;
        logic [7:0] rdata;
    } epiu_state_t;

    localparam epiu_state_t RST_STATE = '{
        sense: SENSE_LOW,
        en_int: 1'b0,
        en_pc: 1'b0,
        flag_int: 1'b0,
        flag_pc: 1'b0,
        gie: 1'b0,
        pcmask: 6'h00,
        pin_s: 1'b1,
        pin_p: 1'b1,
        pc_s: 6'h00,
        pc_p: 6'h00,
        wr_pend: 1'b0,
        widx: 3'h7,
        rdata: 8'h00
    };

endpackage : epiu_pkg

// ### verilog/epiu_top.sv
`timescale 1ns/1ps
// Operation
// R1: Two sense bits pick low level, any change, falling or rising edge.
// R2: Dedicated request passes only with its mask bit 6 and global enable.
// R3: Pin-change request passes only with mask bit 5 and global enable.
// R4: Each pin-change mask bit enables its own input; cleared bits contribute nothing.
// R5: Any enabled pin-change input toggling either way raises the combined request.
// R6: Detection samples the pin level itself, whatever drives the pin.
// R7: Pin-change wake-up is detected without the clock.
// R8: Low-level wake is clockless; edge sensing uses the clock.
// R9: Level mode keeps requesting while the pin stays low.
// R10: Pins are sampled, edges found on samples; pulses over one clock are caught.
// R11: In level mode the source holds the pin low long enough.
// R12: Edge or change sets flag bit 6; vector ack or written one clears it.
// R13: In level mode the dedicated flag is held cleared.
// R14: Pin change sets flag bit 5; vector ack or written one clears it.
// R15: Reserved bits of mask, flag and pin-change mask read as zero.
// R16: Level wake interrupts only if the level is still present afterwards.
// R17: Dedicated and pin-change requests leave as two separate vectors.
// R18: A per-vector acknowledge clears the matching flag.
// R19: A trigger coinciding with a clear leaves the flag set.
module epiu_top (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic DEDICATED_IRQ_PIN,
    input wire logic [epiu_pkg::PC_COUNT-1:0] PIN_CHANGE_INPUTS,
    input wire logic ACK_DEDICATED,
    input wire logic ACK_PIN_CHANGE,
    output logic REQ_DEDICATED,
    output logic REQ_PIN_CHANGE,
    output logic IRQ,
    output logic WAKE
);
    import epiu_pkg::*;

    // ------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------

    // Word index of an address, IDX_NONE for anything unmapped
    function automatic logic [2:0] reg_index(input logic [31:0] addr);
        logic [2:0] idx;
        idx = IDX_NONE;
        if (addr == OFS_SENSE)
            idx = IDX_SENSE;
        else if (addr == OFS_MASK)
            idx = IDX_MASK;
        else if (addr == OFS_FLAG)
            idx = IDX_FLAG;
        else if (addr == OFS_PCMASK)
            idx = IDX_PCMASK;
        else if (addr == OFS_STATUS)
            idx = IDX_STATUS;
        return idx;
    endfunction : reg_index

    // Read value of a register; reserved bits stay zero
    function automatic logic [7:0] read_value(input logic [2:0] idx, input epiu_state_t st);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            IDX_SENSE:
            begin
                v[1:0] = st.sense;
            end
            IDX_MASK:
            begin
                v[BIT_DEDICATED] = st.en_int; // [R15]
                v[BIT_PIN_CHANGE] = st.en_pc;
            end
            IDX_FLAG:
            begin
                v[BIT_DEDICATED] = st.flag_int; // [R15]
                v[BIT_PIN_CHANGE] = st.flag_pc;
            end
            IDX_PCMASK:
            begin
                v[PC_COUNT-1:0] = st.pcmask; // [R15]
            end
            IDX_STATUS:
            begin
                v[BIT_GLOBAL_EN] = st.gie;
            end
            default:
            begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction : read_value

    epiu_state_t s_q;
    epiu_state_t s_d;
    logic accept;
    logic [2:0] aidx;
    logic int_evt;
    logic pc_evt;
    logic clr_int;
    logic clr_pc;

    // ------------------------------------------------------------------
    // Bus slave answers
    // ------------------------------------------------------------------

    // Zero wait states, so every transfer ends in one data-phase cycle
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = {24'h00_0000, s_q.rdata};
    assign accept = HSEL & HREADY & HTRANS[1];
    assign aidx = reg_index(HADDR);

    // ------------------------------------------------------------------
    // Event detection on sampled pins
    // ------------------------------------------------------------------

    // Edges are taken between two samples, never from the raw pin
    always_comb
    begin
        unique case (s_q.sense)
            SENSE_LOW:
            begin
                int_evt = 1'b0; // [R1]
            end
            SENSE_ANY:
            begin
                int_evt = s_q.pin_s ^ s_q.pin_p; // [R1] [R10]
            end
            SENSE_FALL:
            begin
                int_evt = s_q.pin_p & ~s_q.pin_s; // [R1] [R10]
            end
            SENSE_RISE:
            begin
                int_evt = ~s_q.pin_p & s_q.pin_s; // [R1] [R10]
            end
        endcase
    end

    // Toggle either way on any enabled input merges into one event
    assign pc_evt = |((s_q.pc_s ^ s_q.pc_p) & s_q.pcmask); // [R4] [R5]

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Register writes land at the end of the data phase
    always_comb
    begin
        s_d = s_q;
        clr_int = ACK_DEDICATED; // [R18]
        clr_pc = ACK_PIN_CHANGE; // [R18]
        // Pins are read directly, so output-driven pins still trigger
        s_d.pin_s = DEDICATED_IRQ_PIN; // [R6]
        s_d.pin_p = s_q.pin_s;
        s_d.pc_s = PIN_CHANGE_INPUTS; // [R6]
        s_d.pc_p = s_q.pc_s;
        if (s_q.wr_pend)
        begin
            unique case (s_q.widx)
                IDX_SENSE:
                begin
                    s_d.sense = epiu_sense_t'(HWDATA[1:0]); // [R1]
                end
                IDX_MASK:
                begin
                    s_d.en_int = HWDATA[BIT_DEDICATED];
                    s_d.en_pc = HWDATA[BIT_PIN_CHANGE];
                end
                IDX_FLAG:
                begin
                    clr_int = clr_int | HWDATA[BIT_DEDICATED]; // [R12]
                    clr_pc = clr_pc | HWDATA[BIT_PIN_CHANGE]; // [R14]
                end
                IDX_PCMASK:
                begin
                    s_d.pcmask = HWDATA[PC_COUNT-1:0]; // [R4]
                end
                IDX_STATUS:
                begin
                    s_d.gie = HWDATA[BIT_GLOBAL_EN];
                end
                default:
                begin
                    s_d.gie = s_q.gie;
                end
            endcase
        end
        // Clear first, then set, so a coincident event survives
        if (clr_int)
            s_d.flag_int = 1'b0; // [R12]
        if (int_evt)
            s_d.flag_int = 1'b1; // [R12] [R19]
        if (s_d.sense == SENSE_LOW)
            s_d.flag_int = 1'b0; // [R13]
        if (clr_pc)
            s_d.flag_pc = 1'b0; // [R14]
        if (pc_evt)
            s_d.flag_pc = 1'b1; // [R14] [R19]
        // Address phase; unmapped writes are dropped, reads return zero
        s_d.wr_pend = accept & HWRITE & (aidx != IDX_NONE);
        s_d.widx = aidx;
        s_d.rdata = 8'h00;
        if (accept & ~HWRITE)
            s_d.rdata = read_value(aidx, s_d);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
            s_q <= RST_STATE;
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // Requests to the processor
    // ------------------------------------------------------------------

    // Level mode asks as long as the sampled pin stays low, so a level
    // that vanished before start-up ends raises nothing
    assign REQ_DEDICATED = s_q.gie & s_q.en_int
        & ((s_q.sense == SENSE_LOW) ? ~s_q.pin_s : s_q.flag_int); // [R2] [R9] [R16] [R17]
    assign REQ_PIN_CHANGE = s_q.gie & s_q.en_pc & s_q.flag_pc; // [R3] [R17]
    assign IRQ = REQ_DEDICATED | REQ_PIN_CHANGE;

    // Wake path uses the raw pins combinationally, needing no clock;
    // edge modes cannot wake since they rely on the running clock
    assign WAKE = (s_q.en_int & (s_q.sense == SENSE_LOW) & ~DEDICATED_IRQ_PIN)
        | (s_q.en_pc & |((PIN_CHANGE_INPUTS ^ s_q.pc_s) & s_q.pcmask)); // [R7] [R8]

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    a_level_request: assert property ( // [R9]
        (s_q.sense == SENSE_LOW && s_q.gie && s_q.en_int && !s_q.pin_s) |-> REQ_DEDICATED)
        else $error("Level request missing while pin low");

    a_fall_sets_flag: assert property ( // [R12]
        (s_q.sense == SENSE_FALL && s_q.sense == s_d.sense && s_q.pin_p && !s_q.pin_s)
        |=> s_q.flag_int)
        else $error("Falling edge did not set flag");

    a_rise_sets_flag: assert property ( // [R1]
        (s_q.sense == SENSE_RISE && s_q.sense == s_d.sense && !s_q.pin_p && s_q.pin_s)
        |=> s_q.flag_int)
        else $error("Rising edge did not set flag");

    a_pulse_caught: assert property ( // [R10]
        (s_q.sense == SENSE_ANY && $changed(DEDICATED_IRQ_PIN)) ##1 (s_q.sense == SENSE_ANY
        && s_d.sense == SENSE_ANY) |=> s_q.flag_int)
        else $error("Pin change of one clock not caught");

    a_level_flag_clear: assert property ( // [R13]
        (s_q.sense == SENSE_LOW) |-> !s_q.flag_int)
        else $error("Flag set in level mode");

    a_pc_sets_flag: assert property ( // [R5] [R19]
        (|((s_q.pc_s ^ s_q.pc_p) & s_q.pcmask)) |=> s_q.flag_pc)
        else $error("Pin change did not set flag");

    a_pc_ack_clears: assert property ( // [R18]
        (ACK_PIN_CHANGE && s_q.pc_s == s_q.pc_p) |=> !s_q.flag_pc)
        else $error("Acknowledge did not clear pin-change flag");

    a_masked_pin_quiet: assert property ( // [R4]
        (s_q.pcmask == 6'h00 && !s_q.flag_pc) |=> !s_q.flag_pc)
        else $error("Masked pins set the flag");

    a_global_gate: assert property ( // [R2] [R3]
        !s_q.gie |-> !IRQ && !REQ_DEDICATED && !REQ_PIN_CHANGE)
        else $error("Request without global enable");

    a_reserved_zero: assert property ( // [R15]
        $past(accept && !HWRITE && aidx == IDX_FLAG) |-> (HRDATA[7] == 1'b0
        && HRDATA[4:0] == 5'h00))
        else $error("Reserved flag bits read nonzero");

endmodule : epiu_top

// ### verif/epiu_cpu_model.sv
`timescale 1ns/1ps
// --------------------
// CPU vector taker
// --------------------
module epiu_cpu_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic take_en,
    input wire logic req_ded,
    input wire logic req_pc,
    output logic ack_ded,
    output logic ack_pc
);
    // One pulse per take, then a gap so a stale request is never taken twice
    always_ff @(posedge clk)
    begin
        if (!rst_n || ack_ded || ack_pc)
        begin
            ack_ded <= 1'b0;
            ack_pc <= 1'b0;
        end
        else
        begin
            ack_ded <= take_en && req_ded;
            ack_pc <= take_en && req_pc && !req_ded;
        end
    end
endmodule : epiu_cpu_model

// ### verif/epiu_top_tb.sv
`timescale 1ns/1ps
module epiu_top_tb;
    import epiu_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hresp, pin = 1'b1, take_en = 1'b0, ack_d, ack_p, req_d, req_p, irq, wake;
    logic [5:0] pcin = 6'h00;
    wire hready;
    int n_fail = 0;
    int samples_checked = 0;

    // 25 MHz clock
    always #20 clock = ~clock;

    epiu_top dut_u (.CLOCK(clock), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .DEDICATED_IRQ_PIN(pin), .PIN_CHANGE_INPUTS(pcin), .ACK_DEDICATED(ack_d),
        .ACK_PIN_CHANGE(ack_p), .REQ_DEDICATED(req_d), .REQ_PIN_CHANGE(req_p),
        .IRQ(irq), .WAKE(wake));

    epiu_cpu_model cpu_u (.clk(clock), .rst_n(rst_n), .take_en(take_en),
        .req_ded(req_d), .req_pc(req_p), .ack_ded(ack_d), .ack_pc(ack_p));

    // --------------------
    // Helpers
    // --------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // Single transfer; ready is sampled at the rising edge that ends each phase,
    // and only the watchdog ends a wait that never sees it
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clock);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do
        begin
            @(posedge clock);
        end while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do
        begin
            @(posedge clock);
        end while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string m);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(x, e, m);
        check(hresp, 1'b0, "resp");
    endtask : rd_chk

    // Expected dedicated trigger for a mode and a pin transition
    function automatic logic ded_hit(input logic [1:0] md, input logic f, input logic t);
        case (md)
            2'h1: return f != t;
            2'h2: return f && !t;
            2'h3: return !f && t;
            default: return 1'b0;
        endcase
    endfunction : ded_hit

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial
    begin
        tick(20000);
        n_fail++;
        report_and_stop();
    end

    // --------------------
    // Main sequence
    // --------------------
    initial
    begin
        logic [1:0] m;
        logic h;
        logic [5:0] mk, tg;
        void'($urandom(32'h70973b1f));
        tick(10);
        rst_n <= 1'b1;
        rd_chk(OFS_MASK, 32'h0, "mask rst");
        rd_chk(OFS_FLAG, 32'h0, "flag rst");
        rd_chk(32'h14, 32'h0, "unmapped");
        wr(OFS_MASK, 32'hff);
        rd_chk(OFS_MASK, 32'h60, "mask rsvd");
        wr(OFS_PCMASK, 32'hff);
        rd_chk(OFS_PCMASK, 32'h3f, "pcmask rsvd");
        wr(OFS_STATUS, 32'h80);
        // Each sense mode sees a falling then a rising edge
        for (int i = 0; i < 8; i++)
        begin
            m = i[2:1];
            h = ded_hit(m, !i[0], i[0]);
            wr(OFS_SENSE, {30'h0, m});
            wr(OFS_FLAG, 32'h60);
            tick(3);
            // The new pin level, low after a fall and high after a rise, stands through the checks below
            pin <= ~pin;
            tick(4);
            rd_chk(OFS_FLAG, {25'h0, h, 6'h0}, "ded flag");
            @(negedge clock);
            check(req_d, (m == 2'h0) ? !i[0] : h, "ded req");
            check(wake, (m == 2'h0) && !i[0], "ded wake");
        end
        // Enable gating on a standing flag, then the vector is taken
        wr(OFS_MASK, 32'h20);
        @(negedge clock);
        check(req_d, 1'b0, "mask off");
        wr(OFS_MASK, 32'h60);
        wr(OFS_STATUS, 32'h0);
        @(negedge clock);
        check(req_d, 1'b0, "gie off");
        wr(OFS_STATUS, 32'h80);
        @(negedge clock);
        check({req_d, irq}, 2'h3, "gie on");
        @(posedge clock);
        take_en <= 1'b1;
        tick(4);
        take_en <= 1'b0;
        rd_chk(OFS_FLAG, 32'h0, "ded ack");
        // Pin-change masks and toggles, single-bit corners first
        for (int i = 0; i < 24; i++)
        begin
            mk = (i < 6) ? 6'h01 << i : 6'($urandom);
            tg = (i < 6) ? ~mk : 6'($urandom);
            wr(OFS_PCMASK, {26'h0, mk});
            wr(OFS_FLAG, 32'h60);
            h = |(mk & tg);
            pcin <= pcin ^ tg;
            // Wake shows the raw change before the sample catches up
            @(negedge clock);
            check(wake, h, "pc wake");
            tick(4);
            rd_chk(OFS_FLAG, {26'h0, h, 5'h0}, "pc flag");
            @(negedge clock);
            check({req_p, irq}, {h, h}, "pc req");
        end
        // A clearing write and a fresh toggle meet at one edge; the toggle wins
        wr(OFS_PCMASK, 32'h3f);
        fork
            wr(OFS_FLAG, 32'h60);
            begin
                @(posedge clock);
                pcin <= ~pcin;
            end
        join
        rd_chk(OFS_FLAG, 32'h20, "pc clr race");
        // Taken pin-change vector clears its flag
        take_en <= 1'b1;
        pcin <= ~pcin;
        tick(8);
        take_en <= 1'b0;
        rd_chk(OFS_FLAG, 32'h0, "pc ack");
        report_and_stop();
    end
endmodule : epiu_top_tb
